// file: verilog/dcrl_defs.vh
// constants for the dac control and ramp limit register block
`ifndef DCRL_DEFS_VH
`define DCRL_DEFS_VH
`define DCRL_IDX_CTRL        4'h3
`define DCRL_IDX_LOWER       4'h4
`define DCRL_IDX_UPPER       4'h5
`define DCRL_IDX_WAIT_SEL    4'h6
`define DCRL_IDX_RAMP_EN     4'h7
`define DCRL_IDX_STATUS      4'h8
`define DCRL_BIT_SYNC_PD     26
`define DCRL_BIT_CALCLK_PD   25
`define DCRL_BIT_CAL_START   24
`define DCRL_CTRL_RESET      32'h0000_0000
`define DCRL_LIMIT_RESET     32'h0000_0000
`define DCRL_WAIT_00         11'h080
`define DCRL_WAIT_01         11'h100
`define DCRL_WAIT_10         11'h200
`define DCRL_WAIT_11         11'h400
`endif

// file: verilog/dcrl_regs.v
// register bank for dac calibration, sync divider gating and ramp limits
//
// What this block does
// - interval selector 10 gives a wait of 512 reference cycles
// - interval selector 11 gives a wait of 1024 reference cycles
// - interval selector 00 gives 128 cycles, 01 gives 256 cycles
// - control bit 26 clear enables sync divider, set powers it down
// - calibration clock runs only when bits 25 and 26 are both zero
// - writing one to control bit 24 starts an automatic dac calibration
// - limit registers affect output only while ramp enable is one
// - full 32-bit writable lower limit at index 4
// - full 32-bit writable upper limit at index 5
`timescale 1ns/100ps
`include "dcrl_defs.vh"

module dcrl_regs
#(
   parameter CAL_CYCLES = 64          // length of one calibration run in clocks
)
(
   input  wire        clk_i,          // reference clock, 10 MHz
   input  wire        rst_i,          // synchronous reset, active high
   input  wire        cyc_i,          // wishbone cycle
   input  wire        stb_i,          // wishbone strobe
   input  wire        we_i,           // wishbone write enable
   input  wire [5:2]  adr_i,          // wishbone word address
   input  wire [3:0]  sel_i,          // wishbone byte selects
   input  wire [31:0] dat_i,          // wishbone write data
   output reg  [31:0] dat_o,          // wishbone read data
   output reg         ack_o,          // wishbone acknowledge
   output reg         sync_div_en_o,  // sync output divider enabled
   output reg         cal_clk_en_o,   // dac calibration clock enabled
   output reg         cal_busy_o,     // dac calibration in progress
   output reg  [10:0] wait_cycles_o,  // selected wait interval in ref clocks
   output reg  [31:0] lower_eff_o,    // lower limit seen by the ramp datapath
   output reg  [31:0] upper_eff_o     // upper limit seen by the ramp datapath
);

   reg  [31:0] ctrl;
   wire [31:0] lower;
   wire [31:0] upper;
   reg  [1:0]  wait_sel;
   reg         ramp_en;
   reg  [15:0] cal_cnt;
   reg  [10:0] next_wait;
   reg  [31:0] next_rd;

   wire acc      = cyc_i & stb_i & ~ack_o;
   wire wr       = acc & we_i;
   wire wr_lower = wr & (adr_i == `DCRL_IDX_LOWER);
   wire wr_upper = wr & (adr_i == `DCRL_IDX_UPPER);

   // byte-lane merge for a 32-bit word
   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  sel;
      integer k;
      begin
         merge = old_v;
         for (k = 0; k < 4; k = k + 1)
            if (sel[k])
               merge[k*8 +: 8] = new_v[k*8 +: 8];
      end
   endfunction

   // registers; bit 24 is a trigger and does not stay stored
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl     <= `DCRL_CTRL_RESET;
         wait_sel <= 2'h0;
         ramp_en  <= 1'b0;
      end
      else if (wr)
      begin
         case (adr_i)
            `DCRL_IDX_CTRL:
            begin
               ctrl <= merge(ctrl, dat_i, sel_i) & 32'h07FF_FFFF & ~32'h0100_0000;
            end
            `DCRL_IDX_WAIT_SEL:
            begin
               if (sel_i[0])
                  wait_sel <= dat_i[1:0];
            end
            `DCRL_IDX_RAMP_EN:
            begin
               if (sel_i[2])
                  ramp_en <= dat_i[19];
            end
            default:
            begin
               wait_sel <= wait_sel;
            end
         endcase
      end
   end

   // the two limit words share one byte-lane register shape
   dcrl_limit_word #(.WIDTH(32)) i_lower_word
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .we_i  (wr_lower),
      .sel_i (sel_i),
      .dat_i (dat_i),
      .val_o (lower)
   );

   dcrl_limit_word #(.WIDTH(32)) i_upper_word
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .we_i  (wr_upper),
      .sel_i (sel_i),
      .dat_i (dat_i),
      .val_o (upper)
   );

   // calibration run; a new trigger while busy restarts the count
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cal_busy_o <= 1'b0;
         cal_cnt    <= 16'h0000;
      end
      else if (wr && adr_i == `DCRL_IDX_CTRL && sel_i[3] && dat_i[`DCRL_BIT_CAL_START])
      begin
         cal_busy_o <= 1'b1;
         cal_cnt    <= CAL_CYCLES[15:0];
      end
      else if (cal_busy_o)
      begin
         cal_cnt    <= cal_cnt - 16'h0001;
         cal_busy_o <= (cal_cnt != 16'h0001);
      end
   end

   always @*
   begin
      case (wait_sel)
         2'b00:   next_wait = `DCRL_WAIT_00;
         2'b01:   next_wait = `DCRL_WAIT_01;
         2'b10:   next_wait = `DCRL_WAIT_10;
         2'b11:   next_wait = `DCRL_WAIT_11;
         default: next_wait = `DCRL_WAIT_00;
      endcase
   end

   // outputs; limits only reach the datapath while the ramp is on
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync_div_en_o <= 1'b1;
         cal_clk_en_o  <= 1'b1;
         wait_cycles_o <= `DCRL_WAIT_00;
         lower_eff_o   <= 32'h0000_0000;
         upper_eff_o   <= 32'h0000_0000;
      end
      else
      begin
         sync_div_en_o <= ~ctrl[`DCRL_BIT_SYNC_PD];
         cal_clk_en_o  <= ~ctrl[`DCRL_BIT_SYNC_PD] & ~ctrl[`DCRL_BIT_CALCLK_PD];
         wait_cycles_o <= next_wait;
         lower_eff_o   <= ramp_en ? lower : 32'h0000_0000;
         upper_eff_o   <= ramp_en ? upper : 32'h0000_0000;
      end
   end

   always @*
   begin
      case (adr_i)
         `DCRL_IDX_CTRL:     next_rd = ctrl;
         `DCRL_IDX_LOWER:    next_rd = lower;
         `DCRL_IDX_UPPER:    next_rd = upper;
         `DCRL_IDX_WAIT_SEL: next_rd = {30'h0000_0000, wait_sel};
         `DCRL_IDX_RAMP_EN:  next_rd = {12'h000, ramp_en, 19'h0_0000};
         `DCRL_IDX_STATUS:   next_rd = {31'h0000_0000, cal_busy_o};
         default:            next_rd = 32'h0000_0000;
      endcase
   end

   // one wait state: ack one clock after the strobe, dropped the next clock
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end
      else
      begin
         ack_o <= acc;
         dat_o <= (acc && !we_i) ? next_rd : dat_o;
      end
   end

endmodule

// byte-lane writable word, used for each ramp limit
module dcrl_limit_word
#(
   parameter WIDTH = 32                   // bits in the word, a multiple of eight
)
(
   input  wire               clk_i,       // reference clock
   input  wire               rst_i,       // synchronous reset, active high
   input  wire               we_i,        // write strobe for this word
   input  wire [WIDTH/8-1:0] sel_i,       // byte lanes
   input  wire [WIDTH-1:0]   dat_i,       // write data
   output reg  [WIDTH-1:0]   val_o        // stored word
);

   integer k;

   // unselected lanes keep their bytes, so a host may update one byte alone
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         val_o <= `DCRL_LIMIT_RESET;
      end
      else if (we_i)
      begin
         for (k = 0; k < WIDTH/8; k = k + 1)
         begin
            if (sel_i[k])
            begin
               val_o[k*8 +: 8] <= dat_i[k*8 +: 8];
            end
         end
      end
   end

endmodule

// file: test/dcrl_monitor.sv
// checker for the dcrl register bank
`timescale 1ns/100ps
module dcrl_monitor (
   input wire        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, // bus
   input wire        sync_div_en_o, cal_clk_en_o, cal_busy_o, // controls
   input wire [5:2]  adr_i,                                   // index
   input wire [3:0]  sel_i,                                   // lanes
   input wire [31:0] dat_i, dat_o, lower_eff_o, upper_eff_o,  // data
   input wire [10:0] wait_cycles_o                            // wait
);
   wire rq = cyc_i && stb_i && !ack_o;
   wire wc = rq && we_i && adr_i == 4'h3 && sel_i[3];
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("long ack");
   a_ack_due: assert property (rq |=> ack_o) else $error("no ack");
   a_wait_map: assert property (rq && we_i && adr_i == 4'h6 && sel_i[0] |=> ##1
      wait_cycles_o == 11'h080 << $past(dat_i[1:0], 2)) else $error("bad wait");
   a_sync_ctl: assert property (wc |=> ##1 sync_div_en_o == !$past(dat_i[26], 2))
      else $error("bad sync");
   a_calclk_ctl: assert property (wc |=> ##1 cal_clk_en_o == !$past(|dat_i[26:25], 2))
      else $error("bad calclk");
   a_cal_start: assert property (wc && dat_i[24] |-> ##[1:3] cal_busy_o)
      else $error("no cal");
   a_limit_gate: assert property (rq && we_i && adr_i == 4'h7 && sel_i[2] && !dat_i[19]
      |=> ##1 lower_eff_o == 0 && upper_eff_o == 0) else $error("limit leak");
   a_unmapped_rd: assert property (rq && !we_i && adr_i > 4'h8 |=> dat_o == 0)
      else $error("unmapped data");
   cover property (wc && dat_i[24]);
   cover property (lower_eff_o != 0);
   cover property (wait_cycles_o == 11'h400);
endmodule
bind dcrl_regs dcrl_monitor u_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o, .adr_i,
   .sel_i, .dat_i, .dat_o, .sync_div_en_o, .cal_clk_en_o, .cal_busy_o, .lower_eff_o,
   .upper_eff_o, .wait_cycles_o);

// file: test/dcrl_host.sv
// host model driving the wishbone port
`timescale 1ns/100ps
module dcrl_host (
   input wire          clk_i, ack_i,                   // clock, acknowledge
   input wire   [31:0] rd_i,                           // read data
   output logic        cyc_o = 1'b0, stb_o = 1'b0, we_o = 1'b0, // request
   output logic [5:2]  adr_o = 4'h0,                   // index
   output logic [3:0]  sel_o = 4'h0,                   // lanes
   output logic [31:0] wd_o = 32'h0                    // write data
);
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk_i);
      {cyc_o, stb_o, we_o, adr_o, wd_o} <= {2'b11, w, a, d};
      sel_o <= 4'hF;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = rd_i;
      {cyc_o, stb_o} <= 2'b00;
      wd_o <= ~d; // released lines stop showing the old value
   endtask
endmodule

// file: test/tb.sv
// self-checking bench for the dcrl register bank
`timescale 1ns/100ps
`include "dcrl_defs.vh"
module tb;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i, stb_i, we_i, ack_o;
   logic        sync_div_en_o, cal_clk_en_o, cal_busy_o;
   logic [5:2]  adr_i;
   logic [3:0]  sel_i;
   logic [10:0] wait_cycles_o;
   logic [31:0] dat_i, dat_o, lower_eff_o, upper_eff_o, q, lo, hi;
   integer      bad_count = 0, cmp_count = 0, seed = 92, i;
   initial forever #50 clk_i = ~clk_i;
   dcrl_regs #(.CAL_CYCLES(4)) i_dcrl_regs (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
      .sel_i, .dat_i, .dat_o, .ack_o, .sync_div_en_o, .cal_clk_en_o, .cal_busy_o,
      .wait_cycles_o, .lower_eff_o, .upper_eff_o);
   dcrl_host u_host (.clk_i, .ack_i(ack_o), .rd_i(dat_o), .cyc_o(cyc_i), .stb_o(stb_i),
      .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .wd_o(dat_i));
   task chk(input string n, input logic [31:0] e, s);
      cmp_count++;
      if (s !== e)
      begin
         $display("Error %s expected %h seen %h", n, e, s);
         bad_count++;
      end
   endtask
   function logic [10:0] exp_wait(input logic [1:0] s);
      case (s)
         2'b00:   exp_wait = 11'h080;
         2'b01:   exp_wait = 11'h100;
         2'b10:   exp_wait = 11'h200;
         default: exp_wait = 11'h400;
      endcase
   endfunction
   function logic exp_sync(input logic [31:0] c);
      exp_sync = !c[26];
   endfunction
   function logic exp_calclk(input logic [31:0] c);
      exp_calclk = !c[26] && !c[25];
   endfunction
   function logic [31:0] exp_eff(input logic en, input logic [31:0] v);
      exp_eff = en ? v : 32'h0000_0000;
   endfunction
   task wr(input logic [3:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, q);
      @(posedge clk_i);
      #1;
   endtask
   task rd(input logic [3:0] a);
      u_host.xfer(1'b0, a, $random(seed), q);
   endtask
   task final_report;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #2000000;
      bad_count++;
      final_report;
   end
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1 chk("sync", 32'h1, sync_div_en_o);
      wr(`DCRL_IDX_CTRL, 32'h0100_0000);
      chk("busy", 32'h1, cal_busy_o);
      rd(`DCRL_IDX_CTRL);
      chk("ctrl", 32'h0, q);
      for (i = 0; i < 12 && cal_busy_o; i++) @(posedge clk_i);
      #1 chk("busy", 32'h0, cal_busy_o);
      for (i = 0; i < 4; i++)
      begin
         wr(`DCRL_IDX_CTRL, i << 25);
         rd(`DCRL_IDX_CTRL);
         chk("ctrl", i << 25, q);
         chk("sync", exp_sync(i << 25), sync_div_en_o);
         chk("calclk", exp_calclk(i << 25), cal_clk_en_o);
         wr(`DCRL_IDX_WAIT_SEL, i);
         chk("wait", exp_wait(i[1:0]), wait_cycles_o);
      end
      for (i = 0; i < 6; i++)
      begin
         lo = $random(seed);
         hi = $random(seed);
         wr(`DCRL_IDX_LOWER, lo);
         wr(`DCRL_IDX_UPPER, hi);
         rd(`DCRL_IDX_LOWER);
         chk("lower", lo, q);
         rd(`DCRL_IDX_UPPER);
         chk("upper", hi, q);
         wr(`DCRL_IDX_RAMP_EN, i[0] ? 32'h0008_0000 : 32'h0000_0000);
         chk("lower_eff", exp_eff(i[0], lo), lower_eff_o);
         chk("upper_eff", exp_eff(i[0], hi), upper_eff_o);
      end
      wr(4'h9, 32'hFFFF_FFFF);
      rd(4'h9);
      chk("unmapped", 32'h0, q);
      // mid-run reset with every control away from its reset value
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1 chk("wait", 32'h080, wait_cycles_o);
      chk("sync", 32'h1, sync_div_en_o);
      chk("calclk", 32'h1, cal_clk_en_o);
      chk("lower_eff", 32'h0, lower_eff_o);
      chk("upper_eff", 32'h0, upper_eff_o);
      rd(`DCRL_IDX_UPPER);
      chk("upper", 32'h0, q);
      final_report;
   end
endmodule
